// ### logic/lcd_fetch_pkg.sv
package lcd_fetch_pkg;
    localparam logic [11:0] UPPER_BASE_OFS = 12'h000;
    localparam logic [11:0] LOWER_BASE_OFS = 12'h004;
    localparam logic [11:0] PROGRESS_UP_OFS = 12'h008;
    localparam logic [11:0] PROGRESS_LO_OFS = 12'h00c;
    localparam logic [11:0] FRAME_CFG_OFS = 12'h018;
    localparam logic [11:0] FETCH_CTRL_OFS = 12'h01c;
    localparam logic [11:0] WINDOW_CFG_OFS = 12'h020;
    localparam logic [11:0] LINE_CFG_OFS = 12'h024;
    localparam logic [11:0] DITHER_FIRST_OFS = 12'h81c;
    localparam logic [11:0] DITHER_LAST_OFS = 12'h838;
    localparam logic [11:0] POWER_CTRL_OFS = 12'h83c;
    localparam logic [11:0] IRQ_ENABLE_OFS = 12'h848;
    localparam logic [11:0] IRQ_DISABLE_OFS = 12'h84c;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h850;
    localparam logic [11:0] IRQ_STATUS_OFS = 12'h854;
    localparam logic [11:0] IRQ_CLEAR_OFS = 12'h858;
    localparam logic [31:0] DITHER_FIRST_RST = 32'h0000_00a5;
    localparam logic [31:0] DITHER_LAST_RST = 32'h0f5f_faff;
    localparam logic [31:0] POWER_CTRL_RST = 32'h0000_000e;
    localparam int NUM_IRQ = 6;
    localparam int IRQ_MEM_ERR = 0;
    localparam int IRQ_UNDERFLOW = 1;
    localparam int IRQ_OVERWRITE = 2;
    localparam int IRQ_END_FRAME = 3;
    localparam int IRQ_END_LINE = 4;
    localparam int IRQ_LAST_LINE = 5;
    localparam int CTRL_FETCH_EN = 0;
    localparam int CTRL_UPDATE = 1;
    localparam int CTRL_WINDOW_EN = 2;
    localparam int CTRL_DUAL_SCAN = 3;
    localparam int PWR_CORE_ON = 0;
    localparam int PWR_BUSY = 31;
    localparam int FRAME_SIZE_W = 23;
    localparam int STRIDE_W = 16;
    localparam int PIXOFF_LSB = 24;
    localparam int LINE_WORDS_W = 16;
    localparam logic [2:0] FIFO_DEPTH = 3'h4;
    typedef enum logic [1:0] {
        F_IDLE = 2'b00,
        F_REQ = 2'b01,
        F_WAIT = 2'b10
    } fetch_state_e;
endpackage

// ### logic/edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser with a rising-edge pulse on the settled level
module edge_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous level in, results out
    input wire logic async_i,
    output logic level_o,
    output logic rise_o
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } sync_s;
    sync_s st_reg;
    sync_s st_next;
    // Only the second stage and its delayed copy are looked at
    always_comb begin
        st_next = st_reg;
        st_next.meta = async_i;
        st_next.sync = st_reg.meta;
        st_next.prev = st_reg.sync;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign level_o = st_reg.sync;
    assign rise_o = st_reg.sync & ~st_reg.prev;
endmodule
`default_nettype wire

// ### logic/lcd_frame_dma_control.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_frame_dma_control (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Memory read port (AHB-like master, simplified)
    output logic mem_req_o,
    output logic [31:0] mem_addr_o,
    input wire logic mem_ready_i,
    input wire logic mem_err_i,
    input wire logic [31:0] mem_rdata_i,
    // Serializer side, pixel-clock domain levels in, core-clock data and valid pulse out
    input wire logic pixel_clk_i,
    input wire logic ser_rd_i,
    input wire logic line_blank_period_i,
    input wire logic last_line_i,
    output logic [31:0] ser_data_o,
    output logic ser_valid_o,
    // Status
    output logic irq_o,
    output logic core_power_on_o
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [31:0] upper_base;
        logic [31:0] lower_base;
        logic [31:0] act_upper;
        logic [31:0] act_lower;
        logic [lcd_fetch_pkg::FRAME_SIZE_W-1:0] frame_words;
        logic [3:0] ctrl;
        logic [31:0] window_cfg;
        logic [lcd_fetch_pkg::LINE_WORDS_W-1:0] line_words;
        logic [31:0] act_window;
        logic update_pend;
        logic [31:0] dither_first;
        logic [31:0] dither_last;
        logic core_on;
        logic [lcd_fetch_pkg::NUM_IRQ-1:0] mask;
        logic [lcd_fetch_pkg::NUM_IRQ-1:0] status;
        lcd_fetch_pkg::fetch_state_e fstate;
        logic [31:0] addr;
        logic [lcd_fetch_pkg::FRAME_SIZE_W-1:0] cnt;
        logic [lcd_fetch_pkg::LINE_WORDS_W-1:0] lcnt;
        logic lower_half;
        logic [31:0] fifo0;
        logic [31:0] fifo1;
        logic [31:0] fifo2;
        logic [31:0] fifo3;
        logic [1:0] wp;
        logic [1:0] rp;
        logic [2:0] level;
        logic [31:0] out_data;
        logic out_valid;
    } state_s;
    state_s st_reg;
    state_s st_next;
    logic pclk_rise;
    logic rd_sync;
    logic blank_rise;
    logic last_sync;
    logic wb_wr;
    logic wb_rd;
    logic [31:0] wmask;
    logic [lcd_fetch_pkg::NUM_IRQ-1:0] ev;
    logic [31:0] fifo_word;

    // Pins from the panel side pass two flops first
    edge_sync u_pclk (.clk_i(clk_i), .rst_i(rst_i), .async_i(pixel_clk_i),
        .level_o(), .rise_o(pclk_rise));
    edge_sync u_rd (.clk_i(clk_i), .rst_i(rst_i), .async_i(ser_rd_i),
        .level_o(rd_sync), .rise_o());
    edge_sync u_blank (.clk_i(clk_i), .rst_i(rst_i), .async_i(line_blank_period_i),
        .level_o(), .rise_o(blank_rise));
    edge_sync u_last (.clk_i(clk_i), .rst_i(rst_i), .async_i(last_line_i),
        .level_o(last_sync), .rise_o());

    // Bus strobes and byte-lane mask
    assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~st_reg.ack;
    assign wb_rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~st_reg.ack;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // FIFO head word
    always_comb begin
        case (st_reg.rp)
            2'h0: fifo_word = st_reg.fifo0;
            2'h1: fifo_word = st_reg.fifo1;
            2'h2: fifo_word = st_reg.fifo2;
            default: fifo_word = st_reg.fifo3;
        endcase
    end

    // Whole next-state computation
    always_comb begin
        logic pop;
        logic push;
        logic reload;
        logic fetch_go;
        st_next = st_reg;
        pop = 1'b0;
        push = 1'b0;
        reload = 1'b0;
        ev = '0;
        fetch_go = st_reg.ctrl[lcd_fetch_pkg::CTRL_FETCH_EN] & st_reg.core_on;
        st_next.ack = wb_wr | wb_rd;
        // Register writes
        if (wb_wr) begin
            case (wb_adr_i)
                lcd_fetch_pkg::UPPER_BASE_OFS: begin
                    st_next.upper_base = ((st_reg.upper_base & ~wmask) | (wb_dat_i & wmask))
                        & 32'hffff_fffc;
                end
                lcd_fetch_pkg::LOWER_BASE_OFS: begin
                    st_next.lower_base = (st_reg.lower_base & ~wmask) | (wb_dat_i & wmask);
                end
                lcd_fetch_pkg::FRAME_CFG_OFS: begin
                    st_next.frame_words = wb_dat_i[lcd_fetch_pkg::FRAME_SIZE_W-1:0];
                end
                lcd_fetch_pkg::FETCH_CTRL_OFS: begin
                    st_next.ctrl = wb_dat_i[3:0];
                    st_next.ctrl[lcd_fetch_pkg::CTRL_UPDATE] = 1'b0;
                    if (wb_dat_i[lcd_fetch_pkg::CTRL_UPDATE]) begin
                        st_next.update_pend = 1'b1;
                    end
                end
                lcd_fetch_pkg::WINDOW_CFG_OFS: begin
                    st_next.window_cfg = (st_reg.window_cfg & ~wmask) | (wb_dat_i & wmask);
                end
                lcd_fetch_pkg::LINE_CFG_OFS: begin
                    st_next.line_words = wb_dat_i[lcd_fetch_pkg::LINE_WORDS_W-1:0];
                end
                lcd_fetch_pkg::DITHER_FIRST_OFS: begin
                    st_next.dither_first = (st_reg.dither_first & ~wmask) | (wb_dat_i & wmask);
                end
                lcd_fetch_pkg::DITHER_LAST_OFS: begin
                    st_next.dither_last = (st_reg.dither_last & ~wmask) | (wb_dat_i & wmask);
                end
                lcd_fetch_pkg::POWER_CTRL_OFS: begin
                    st_next.core_on = wb_dat_i[lcd_fetch_pkg::PWR_CORE_ON];
                end
                lcd_fetch_pkg::IRQ_ENABLE_OFS: begin
                    st_next.mask = st_reg.mask | wb_dat_i[lcd_fetch_pkg::NUM_IRQ-1:0];
                end
                lcd_fetch_pkg::IRQ_DISABLE_OFS: begin
                    st_next.mask = st_reg.mask & ~wb_dat_i[lcd_fetch_pkg::NUM_IRQ-1:0];
                end
                lcd_fetch_pkg::IRQ_CLEAR_OFS: begin
                    st_next.status = st_reg.status & ~wb_dat_i[lcd_fetch_pkg::NUM_IRQ-1:0];
                end
                default: begin
                end
            endcase
        end
        // Register reads
        if (wb_rd) begin
            case (wb_adr_i)
                lcd_fetch_pkg::UPPER_BASE_OFS: st_next.rdata = st_reg.upper_base;
                lcd_fetch_pkg::LOWER_BASE_OFS: st_next.rdata = st_reg.lower_base;
                lcd_fetch_pkg::PROGRESS_UP_OFS: begin
                    st_next.rdata = st_reg.lower_half ? 32'h0 :
                        {9'h0, st_reg.cnt};
                end
                lcd_fetch_pkg::PROGRESS_LO_OFS: begin
                    st_next.rdata = st_reg.lower_half ? {9'h0, st_reg.cnt} : 32'h0;
                end
                lcd_fetch_pkg::FRAME_CFG_OFS: st_next.rdata = {9'h0, st_reg.frame_words};
                lcd_fetch_pkg::FETCH_CTRL_OFS: st_next.rdata = {28'h0, st_reg.ctrl};
                lcd_fetch_pkg::WINDOW_CFG_OFS: st_next.rdata = st_reg.window_cfg;
                lcd_fetch_pkg::LINE_CFG_OFS: st_next.rdata = {16'h0, st_reg.line_words};
                lcd_fetch_pkg::DITHER_FIRST_OFS: st_next.rdata = st_reg.dither_first;
                lcd_fetch_pkg::DITHER_LAST_OFS: st_next.rdata = st_reg.dither_last;
                lcd_fetch_pkg::POWER_CTRL_OFS: begin
                    st_next.rdata = {(st_reg.fstate != lcd_fetch_pkg::F_IDLE) | st_reg.core_on,
                        30'h0, st_reg.core_on};
                end
                lcd_fetch_pkg::IRQ_MASK_OFS: st_next.rdata = {26'h0, st_reg.mask};
                lcd_fetch_pkg::IRQ_STATUS_OFS: st_next.rdata = {26'h0, st_reg.status};
                default: st_next.rdata = 32'h0;
            endcase
        end
        // Serializer pops one word per rising pixel-clock edge while it asks
        if (pclk_rise && rd_sync) begin
            if (st_reg.level == 3'h0) begin
                ev[lcd_fetch_pkg::IRQ_UNDERFLOW] = 1'b1;
            end else begin
                pop = 1'b1;
                st_next.out_data = fifo_word;
            end
        end
        st_next.out_valid = pop;
        // Fetch engine
        case (st_reg.fstate)
            lcd_fetch_pkg::F_IDLE: begin
                if (fetch_go) begin
                    reload = 1'b1;
                    st_next.fstate = lcd_fetch_pkg::F_REQ;
                end
            end
            lcd_fetch_pkg::F_REQ: begin
                if (!fetch_go) begin
                    st_next.fstate = lcd_fetch_pkg::F_IDLE;
                end else if (st_reg.level < lcd_fetch_pkg::FIFO_DEPTH) begin
                    st_next.fstate = lcd_fetch_pkg::F_WAIT;
                end
            end
            lcd_fetch_pkg::F_WAIT: begin
                if (mem_err_i) begin
                    ev[lcd_fetch_pkg::IRQ_MEM_ERR] = 1'b1;
                    st_next.fstate = lcd_fetch_pkg::F_REQ;
                end else if (mem_ready_i) begin
                    if (st_reg.level == lcd_fetch_pkg::FIFO_DEPTH && !pop) begin
                        ev[lcd_fetch_pkg::IRQ_OVERWRITE] = 1'b1;
                    end else begin
                        push = 1'b1;
                    end
                    st_next.cnt = st_reg.cnt + 1'b1;
                    st_next.lcnt = st_reg.lcnt + 1'b1;
                    st_next.addr = st_reg.addr + 32'h4;
                    // Window mode jumps the stride at line end
                    if (st_reg.act_window[lcd_fetch_pkg::STRIDE_W] &&
                        st_reg.lcnt + 1'b1 == st_reg.line_words) begin
                        st_next.lcnt = '0;
                        st_next.addr = st_reg.addr + 32'h4 +
                            {14'h0, st_reg.act_window[lcd_fetch_pkg::STRIDE_W-1:0], 2'b00};
                    end
                    if (st_reg.cnt + 1'b1 == st_reg.frame_words) begin
                        if (st_reg.ctrl[lcd_fetch_pkg::CTRL_DUAL_SCAN] && !st_reg.lower_half) begin
                            st_next.lower_half = 1'b1;
                            st_next.cnt = '0;
                            st_next.lcnt = '0;
                            st_next.addr = st_reg.act_lower;
                        end else begin
                            reload = 1'b1;
                        end
                    end
                    st_next.fstate = lcd_fetch_pkg::F_REQ;
                end
            end
            default: st_next.fstate = lcd_fetch_pkg::F_IDLE;
        endcase
        // Frame boundary: shadow copies go live, in window or dual-scan mode only with an update pending
        if (reload) begin
            if (!(st_reg.ctrl[lcd_fetch_pkg::CTRL_DUAL_SCAN] ||
                  st_reg.ctrl[lcd_fetch_pkg::CTRL_WINDOW_EN]) || st_reg.update_pend) begin
                st_next.act_upper = st_reg.upper_base;
                st_next.act_lower = st_reg.lower_base;
                st_next.act_window = st_reg.ctrl[lcd_fetch_pkg::CTRL_WINDOW_EN] ?
                    {st_reg.window_cfg[31:17], 1'b1, st_reg.window_cfg[15:0]} : 32'h0;
                st_next.update_pend = 1'b0;
                st_next.addr = st_reg.upper_base;
            end else begin
                st_next.addr = st_reg.act_upper;
            end
            st_next.cnt = '0;
            st_next.lcnt = '0;
            st_next.lower_half = 1'b0;
            ev[lcd_fetch_pkg::IRQ_END_FRAME] = 1'b1;
        end
        // Line blanking while the engine rests
        if (blank_rise && st_reg.fstate != lcd_fetch_pkg::F_WAIT) begin
            ev[lcd_fetch_pkg::IRQ_END_LINE] = 1'b1;
            ev[lcd_fetch_pkg::IRQ_LAST_LINE] = last_sync;
        end
        // FIFO storage
        if (push) begin
            case (st_reg.wp)
                2'h0: st_next.fifo0 = mem_rdata_i;
                2'h1: st_next.fifo1 = mem_rdata_i;
                2'h2: st_next.fifo2 = mem_rdata_i;
                default: st_next.fifo3 = mem_rdata_i;
            endcase
            st_next.wp = st_reg.wp + 2'h1;
        end
        if (pop) begin
            st_next.rp = st_reg.rp + 2'h1;
        end
        st_next.level = st_reg.level + {2'h0, push} - {2'h0, pop};
        // Events win over a clear in the same cycle
        st_next.status = st_next.status | ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.dither_first <= lcd_fetch_pkg::DITHER_FIRST_RST;
            st_reg.dither_last <= lcd_fetch_pkg::DITHER_LAST_RST;
            st_reg.fstate <= lcd_fetch_pkg::F_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.rdata;
    assign mem_req_o = st_reg.fstate == lcd_fetch_pkg::F_WAIT;
    assign mem_addr_o = st_reg.addr;
    assign ser_data_o = st_reg.out_data;
    assign ser_valid_o = st_reg.out_valid;
    assign irq_o = |(st_reg.status & st_reg.mask);
    assign core_power_on_o = st_reg.core_on;
endmodule
`default_nettype wire

// ### tb/lcd_fetch_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_fetch_properties (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Memory and serializer
    input wire logic mem_req_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic mem_ready_i,
    input wire logic mem_err_i,
    input wire logic ser_valid_o,
    input wire logic core_power_on_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic retry_reg;
    logic [31:0] err_addr_reg;
    // Remember the word that drew an error until the next request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            retry_reg <= 1'b0;
            err_addr_reg <= 32'h0;
        end else if (mem_req_o && mem_err_i) begin
            retry_reg <= 1'b1;
            err_addr_reg <= mem_addr_o;
        end else if ($rose(mem_req_o)) begin
            retry_reg <= 1'b0;
        end
    end
    // Request taken by the register slave
    sequence s_wb_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Memory request still waiting for its answer
    sequence s_mem_wait;
        mem_req_o && !mem_ready_i && !mem_err_i;
    endsequence
    a_ack_next: assert property (s_wb_take |=> wb_ack_o)
        else $error("bus request not acknowledged in the next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_upper_low_zero: assert property (
        s_wb_take ##0 (!wb_we_i && wb_adr_i == lcd_fetch_pkg::UPPER_BASE_OFS)
        |=> wb_dat_o[1:0] == 2'b00)
        else $error("upper base low bits not zero");
    a_req_hold: assert property (s_mem_wait |=> mem_req_o && $stable(mem_addr_o))
        else $error("memory request changed before its answer");
    a_req_release: assert property (
        mem_req_o && (mem_ready_i || mem_err_i) |=> !mem_req_o)
        else $error("memory request kept after its answer");
    a_fetch_powered: assert property ($rose(mem_req_o) |-> core_power_on_o)
        else $error("fetch started without core power");
    a_retry_addr: assert property (
        $rose(mem_req_o) && retry_reg |-> mem_addr_o == err_addr_reg)
        else $error("failed word not fetched again");
    a_valid_single: assert property (ser_valid_o |=> !ser_valid_o)
        else $error("serializer word valid longer than one cycle");
endmodule
bind lcd_frame_dma_control lcd_fetch_properties i_lcd_fetch_properties (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .mem_req_o,
    .mem_addr_o, .mem_ready_i, .mem_err_i, .ser_valid_o, .core_power_on_o);
`default_nettype wire

// ### tb/lcd_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
    // Control from the bench
    input wire logic run_i,
    input wire logic rd_en_i,
    // Panel side towards the block
    output logic pixel_clk_o,
    output logic ser_rd_o,
    output logic line_blank_period_o,
    output logic last_line_o
);
    int pix = 0;
    // Pixel clock runs only while a frame is shown, in its own phase
    initial begin
        pixel_clk_o = 1'b0;
        #1.3;
        forever begin
            #80;
            pixel_clk_o = run_i ? ~pixel_clk_o : 1'b0;
        end
    end
    // Twelve active pixels then four blanking; every fourth line is last
    always @(posedge pixel_clk_o) pix <= pix + 1;
    assign line_blank_period_o = (pix % 16) >= 12;
    assign last_line_o = ((pix / 16) % 4) == 3;
    // Words are asked for only outside blanking
    assign ser_rd_o = rd_en_i && !line_blank_period_o;
endmodule
`default_nettype wire

// ### tb/lcd_frame_dma_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_frame_dma_control_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, mem_rdata_i = 32'h0, rd_q, wb_dat_o, mem_addr_o, ser_data_o;
    logic mem_ready_i = 1'b0, mem_err_i = 1'b0, err_next = 1'b0, run = 1'b0, rd_en = 1'b0;
    logic wb_ack_o, mem_req_o, ser_valid_o, irq_o, core_power_on_o;
    logic pixel_clk, ser_rd, blank, last_line;
    logic [31:0] words [5];
    int mem_wait = 0, err_total = 0, comparisons = 0;
    // Core clock
    always #2 clk_i = ~clk_i;
    lcd_frame_dma_control i_lcd_frame_dma_control (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_ready_i(mem_ready_i),
        .mem_err_i(mem_err_i), .mem_rdata_i(mem_rdata_i), .pixel_clk_i(pixel_clk),
        .ser_rd_i(ser_rd), .line_blank_period_i(blank), .last_line_i(last_line),
        .ser_data_o(ser_data_o), .ser_valid_o(ser_valid_o), .irq_o(irq_o),
        .core_power_on_o(core_power_on_o));
    lcd_panel_model i_lcd_panel_model (.run_i(run), .rd_en_i(rd_en), .pixel_clk_o(pixel_clk),
        .ser_rd_o(ser_rd), .line_blank_period_o(blank), .last_line_o(last_line));
    // Memory answers after three cycles; data is the address with a marker
    always @(posedge clk_i) begin
        mem_ready_i <= 1'b0;
        mem_err_i <= 1'b0;
        mem_rdata_i <= ~mem_rdata_i;
        if (mem_req_o && !mem_ready_i && !mem_err_i && mem_wait == 2) begin
            mem_wait <= 0;
            if (err_next) begin
                mem_err_i <= 1'b1;
                err_next <= 1'b0;
            end else begin
                mem_ready_i <= 1'b1;
                mem_rdata_i <= mem_addr_o ^ 32'h5a5a_0000;
            end
        end else if (mem_req_o && !mem_ready_i && !mem_err_i) begin
            mem_wait <= mem_wait + 1;
        end
    end
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic bus cycle, held until acknowledged
    task automatic wb_cycle(input logic we, input logic [11:0] adr, input logic [31:0] dat);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        if (n >= 100) begin
            err_total++;
            complete_run();
        end
        rd_q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    // Read status until a bit shows, bounded
    task automatic poll_bit(input int b);
        int n = 0;
        do begin
            wb_cycle(1'b0, lcd_fetch_pkg::IRQ_STATUS_OFS, 32'h0);
            n++;
        end while (rd_q[b] !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            err_total++;
            complete_run();
        end
    endtask
    task automatic sc_reset_values();
        wb_cycle(1'b0, lcd_fetch_pkg::DITHER_FIRST_OFS, 32'h0);
        check(rd_q, lcd_fetch_pkg::DITHER_FIRST_RST);
        wb_cycle(1'b0, lcd_fetch_pkg::DITHER_LAST_OFS, 32'h0);
        check(rd_q, lcd_fetch_pkg::DITHER_LAST_RST);
        wb_cycle(1'b0, lcd_fetch_pkg::IRQ_STATUS_OFS, 32'h0);
        check(rd_q, 32'h0);
        wb_cycle(1'b0, 12'h3f0, 32'h0);
        check(rd_q, 32'h0);
        check({31'h0, core_power_on_o}, 32'h0);
    endtask
    task automatic sc_base_align();
        wb_cycle(1'b1, lcd_fetch_pkg::UPPER_BASE_OFS, 32'h0000_1003);
        wb_cycle(1'b0, lcd_fetch_pkg::UPPER_BASE_OFS, 32'h0);
        check(rd_q, 32'h0000_1000);
    endtask
    task automatic sc_fetch_start();
        int n = 0;
        wb_cycle(1'b1, lcd_fetch_pkg::FRAME_CFG_OFS, 32'h0000_0010);
        wb_cycle(1'b1, lcd_fetch_pkg::LINE_CFG_OFS, 32'h0000_0010);
        wb_cycle(1'b1, lcd_fetch_pkg::FETCH_CTRL_OFS, 32'h0000_0001);
        repeat (20) @(posedge clk_i);
        check({31'h0, mem_req_o}, 32'h0);
        wb_cycle(1'b1, lcd_fetch_pkg::POWER_CTRL_OFS, 32'h0000_0001);
        while (mem_req_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 100) begin
            err_total++;
            complete_run();
        end
        check(mem_addr_o, 32'h0000_1000);
        poll_bit(lcd_fetch_pkg::IRQ_END_FRAME);
        check(rd_q, 32'h0000_0008);
    endtask
    task automatic sc_serial();
        int k = 0;
        int n = 0;
        rd_en <= 1'b1;
        run <= 1'b1;
        while (k < 2 && n < 5000) begin
            @(posedge clk_i);
            n++;
            if (ser_valid_o === 1'b1) begin
                words[k] = ser_data_o;
                k++;
            end
        end
        check(words[0], 32'h5a5a_1000);
        check(words[1], 32'h5a5a_1004);
        wb_cycle(1'b1, lcd_fetch_pkg::POWER_CTRL_OFS, 32'h0);
        wb_cycle(1'b1, lcd_fetch_pkg::FETCH_CTRL_OFS, 32'h0);
        poll_bit(lcd_fetch_pkg::IRQ_UNDERFLOW);
        check({31'h0, rd_q[lcd_fetch_pkg::IRQ_UNDERFLOW]}, 32'h1);
        poll_bit(lcd_fetch_pkg::IRQ_LAST_LINE);
        check({31'h0, rd_q[lcd_fetch_pkg::IRQ_END_LINE]}, 32'h1);
        rd_en <= 1'b0;
        run <= 1'b0;
        repeat (10) @(posedge clk_i);
        wb_cycle(1'b1, lcd_fetch_pkg::IRQ_CLEAR_OFS, 32'h0000_003f);
        wb_cycle(1'b0, lcd_fetch_pkg::IRQ_STATUS_OFS, 32'h0);
        check(rd_q, 32'h0);
    endtask
    task automatic sc_mem_error();
        wb_cycle(1'b1, lcd_fetch_pkg::IRQ_ENABLE_OFS, 32'h0000_0001);
        wb_cycle(1'b0, lcd_fetch_pkg::IRQ_MASK_OFS, 32'h0);
        check(rd_q, 32'h0000_0001);
        check({31'h0, irq_o}, 32'h0);
        err_next <= 1'b1;
        wb_cycle(1'b1, lcd_fetch_pkg::FETCH_CTRL_OFS, 32'h0000_0001);
        wb_cycle(1'b1, lcd_fetch_pkg::POWER_CTRL_OFS, 32'h0000_0001);
        poll_bit(lcd_fetch_pkg::IRQ_MEM_ERR);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        wb_cycle(1'b1, lcd_fetch_pkg::IRQ_DISABLE_OFS, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        wb_cycle(1'b1, lcd_fetch_pkg::POWER_CTRL_OFS, 32'h0);
        wb_cycle(1'b1, lcd_fetch_pkg::FETCH_CTRL_OFS, 32'h0);
        repeat (20) @(posedge clk_i);
        wb_cycle(1'b1, lcd_fetch_pkg::IRQ_CLEAR_OFS, 32'h0000_003f);
        wb_cycle(1'b0, lcd_fetch_pkg::IRQ_STATUS_OFS, 32'h0);
        check(rd_q, 32'h0);
    endtask
    task automatic sc_window_dual();
        int k = 0;
        int n = 0;
        logic req_q = 1'b0;
        logic [31:0] want [5] = '{32'h2000, 32'h200c, 32'h3000, 32'h300c, 32'h2000};
        wb_cycle(1'b1, lcd_fetch_pkg::UPPER_BASE_OFS, 32'h2000);
        wb_cycle(1'b1, lcd_fetch_pkg::LOWER_BASE_OFS, 32'h3000);
        wb_cycle(1'b1, lcd_fetch_pkg::WINDOW_CFG_OFS, 32'h2);
        wb_cycle(1'b1, lcd_fetch_pkg::FRAME_CFG_OFS, 32'h2);
        wb_cycle(1'b1, lcd_fetch_pkg::LINE_CFG_OFS, 32'h1);
        wb_cycle(1'b1, lcd_fetch_pkg::FETCH_CTRL_OFS, 32'hf);
        rd_en <= 1'b1;
        run <= 1'b1;
        wb_cycle(1'b1, lcd_fetch_pkg::POWER_CTRL_OFS, 32'h1);
        while (k < 5 && n < 3000) begin
            @(posedge clk_i);
            n++;
            if (mem_req_o === 1'b1 && !req_q) begin
                words[k] = mem_addr_o;
                k++;
                // New base without update must not go live
                if (k == 1) wb_cycle(1'b1, lcd_fetch_pkg::UPPER_BASE_OFS, 32'h4000);
            end
            req_q = mem_req_o;
        end
        for (int i = 0; i < 5; i++) check(words[i], want[i]);
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        sc_reset_values();
        sc_base_align();
        sc_fetch_start();
        sc_serial();
        sc_mem_error();
        sc_window_dual();
        complete_run();
    end
endmodule
`default_nettype wire
